// >>> design/buck_params.svh
`ifndef BUCK_PARAMS_SVH
`define BUCK_PARAMS_SVH
`define CLK_KHZ       250000
`define CLK_NS        4
`define SW_FREQ_KHZ   1000
`define SW_PERIOD_CYC (`CLK_KHZ / `SW_FREQ_KHZ)
`define DEAD_NS       8
`define DEAD_CYC      ((`DEAD_NS + `CLK_NS - 1) / `CLK_NS)
`define SS_SLOW_MS    8
`define SS_FAST_MS    4
`define RETRY_MS      15
`define SS_SLOW_CYC   (`SS_SLOW_MS * `CLK_KHZ)
`define SS_FAST_CYC   (`SS_FAST_MS * `CLK_KHZ)
`define RETRY_CYC     (`RETRY_MS * `CLK_KHZ)
`define ADDR_CTRL     8'h00
`define ADDR_VOUT     8'h04
`define ADDR_PEAK     8'h08
`define ADDR_STAT     8'h0c
`define CTRL_SW_ON    0
`define CTRL_AND      1
`define CTRL_FAST     2
`define VOUT_RST      7'h24
`define VOUT_MAX      7'h78
`define VOUT_BIAS_LO  7'h24
`define VOUT_BIAS_HI  7'h46
`define PEAK_RST      2'h0
`define PEAK_FIXED    2'h3
`define HICCUP_LIM    4'hf
`define SY_EN         0
`define SY_IOV        1
`define SY_UVLO       2
`define SY_HOT        3
`define SY_STRAP      4
`define SY_A_HIGHER   5
`define SY_A_OVER_B   6
`define SY_B_OVER_A   7
`define SY_TRIP       8
`define SY_LIM        9
`define SY_ZX         10
`define SY_INREG      11
`define SY_LIGHT      12
`define SY_WAKE       13
`define SY_A92        14
`define SY_B90        15
`define SY_QTR        16
`define NSYNC         17
`endif

// >>> design/buck_pkg.sv
package buck_pkg;
`include "buck_params.svh"
	typedef enum logic [2:0] {
		MUX_OFF, MUX_A, MUX_B, MUX_GAP_A, MUX_GAP_B
	} mux_t;
	typedef enum logic [2:0] {
		PWR_OFF, PWR_RAMP, PWR_RUN, PWR_STBY, PWR_RETRY
	} pwr_t;
	typedef enum logic [2:0] {
		PH_IDLE, PH_DEAD_H, PH_HIGH, PH_DEAD_L, PH_LOW
	} phase_t;
	typedef struct packed {
		logic [`NSYNC-1:0] sync1;
		logic [`NSYNC-1:0] sync2;
		logic [`NSYNC-1:0] sync3;
		logic [`NSYNC-1:0] filt;
		mux_t              mux;
		pwr_t              pwr;
		phase_t            phase;
		logic [21:0]       tmr;
		logic [3:0]        dead;
		logic [7:0]        tick_cnt;
		logic              tick;
		logic [3:0]        peak_limit_strap_cnt;
		logic              sw_on;
		logic              ctl_and;
		logic              ramp_fast;
		logic [6:0]        vout;
		logic [1:0]        peak;
		logic              en;
		logic              pg;
		logic              a_on;
		logic              b_on;
		logic              hs;
		logic              ls;
		logic              hiz;
		logic              stby;
		logic              bias_on;
		logic              bias_out;
		logic              ramp;
		logic              pg_oe;
		logic [1:0]        peak_eff;
		logic [7:0]        rdata;
	} st_t;
endpackage

// >>> design/buck_mux_control_logic.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "buck_params.svh"
// Function
// - only the higher supply channel is on, never both together
// - channel selection runs only while enabled; both channels off otherwise
// - switch to the off channel only when it leads by 200mV
// - both supplies have equal priority in selection
// - each high-side on-time starts from a 1MHz clock pulse
// - current comparator ends the on-time; off-time turns low side on
// - dead time with both switches off at every transition
// - low side forced off when current falls below zero-cross level
// - light load in regulation enters standby, switch node floats
// - standby wakes and resumes switching when output drops below 99%
// - enable is pin OR software bit, or AND when combine bit set
// - software enable and combine bit reset to 0, giving OR
// - bias regulator on when enable pin high or interface supply valid
// - internal feedback 3.3V to 5.0V moves bias onto output
// - ramp time select picks 8ms or 4ms soft-start, 8ms default
// - soft-start on enable, undervoltage exit and fault retry
// - output good releases above 92 percent, pulls low below 90
// - with strap low the field picks 700mA to 1000mA limit
// - configuration reset returns the limit field to 700mA
// - with strap high the limit is fixed at 1000mA
// - output target programmable 1.5V to 7.5V in 50mV steps
// - configuration resets on supply undervoltage or invalid interface
// - 15 limited on-times below quarter target stop and retry later
module buck_mux_control_logic #(
	parameter logic [21:0] SS_SLOW_CYC  = 22'(`SS_SLOW_CYC),
	parameter logic [21:0] SS_FAST_CYC  = 22'(`SS_FAST_CYC),
	parameter logic [21:0] RETRY_CYC    = 22'(`RETRY_CYC),
	parameter logic        INTERNAL_FB  = 1'b1,
	parameter logic [6:0]  VOUT_DEFAULT = `VOUT_RST
) (
	// clock and reset
	input  wire logic       CLK_I,
	input  wire logic       NRST_I,
	// register port
	input  wire logic [7:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WE_I,
	input  wire logic       RE_I,
	output logic      [7:0] RDATA_O,
	// enable, supplies and straps
	input  wire logic       EN_PIN_I,
	input  wire logic       IFACE_SUPPLY_VALID_I,
	input  wire logic       SUP_UVLO_I,
	input  wire logic       OVERTEMP_I,
	input  wire logic       PEAK_LIMIT_STRAP_I,
	// supply comparators
	input  wire logic       SUPPLY_A_HIGHER_I,
	input  wire logic       SUPPLY_A_OVER_B_I,
	input  wire logic       SUPPLY_B_OVER_A_I,
	// current comparators
	input  wire logic       PWM_TRIP_I,
	input  wire logic       CUR_LIMIT_I,
	input  wire logic       ZERO_CROSS_I,
	// output comparators
	input  wire logic       OUT_IN_REG_I,
	input  wire logic       LIGHT_LOAD_I,
	input  wire logic       OUT_BELOW_WAKE_I,
	input  wire logic       OUT_ABOVE_92_I,
	input  wire logic       OUT_BELOW_90_I,
	input  wire logic       OUT_BELOW_QUARTER_I,
	// supply channels
	output logic            SUPPLY_A_ON_O,
	output logic            SUPPLY_B_ON_O,
	// power stage
	output logic            HIGH_SIDE_SWITCH_O,
	output logic            LOW_SIDE_SWITCH_O,
	output logic            SWITCH_NODE_HIZ_O,
	output logic            STANDBY_O,
	output logic            RAMP_ACTIVE_O,
	output logic      [1:0] PEAK_LIMIT_O,
	output logic      [6:0] VOUT_CODE_O,
	// bias
	output logic            BIAS_REG_ON_O,
	output logic            BIAS_TO_OUT_O,
	// open-drain output good
	output logic            OUTPUT_GOOD_FLAG_O,
	output logic            OUTPUT_GOOD_FLAG_OE_O
);
	import buck_pkg::*;

	st_t               st_ff;
	st_t               nxt_st;
	logic [`NSYNC-1:0] pins;
	logic [`NSYNC-1:0] f;
	logic              swing;
	logic              stop;
	logic              go;
	logic              hic;
	logic              cfg_rst;

	// keep a bit until the second and third stages agree
	function automatic logic [`NSYNC-1:0] settle(
		input logic [`NSYNC-1:0] a,
		input logic [`NSYNC-1:0] b,
		input logic [`NSYNC-1:0] h
	);
		settle = (a & b) | (h & (a ^ b));
	endfunction

	function automatic logic [21:0] dec22(input logic [21:0] v);
		dec22 = (v == 22'h0) ? v : v - 22'h1;
	endfunction

	assign pins[`SY_EN]       = EN_PIN_I;
	assign pins[`SY_IOV]      = IFACE_SUPPLY_VALID_I;
	assign pins[`SY_UVLO]     = SUP_UVLO_I;
	assign pins[`SY_HOT]      = OVERTEMP_I;
	assign pins[`SY_STRAP]    = PEAK_LIMIT_STRAP_I;
	assign pins[`SY_A_HIGHER] = SUPPLY_A_HIGHER_I;
	assign pins[`SY_A_OVER_B] = SUPPLY_A_OVER_B_I;
	assign pins[`SY_B_OVER_A] = SUPPLY_B_OVER_A_I;
	assign pins[`SY_TRIP]     = PWM_TRIP_I;
	assign pins[`SY_LIM]      = CUR_LIMIT_I;
	assign pins[`SY_ZX]       = ZERO_CROSS_I;
	assign pins[`SY_INREG]    = OUT_IN_REG_I;
	assign pins[`SY_LIGHT]    = LIGHT_LOAD_I;
	assign pins[`SY_WAKE]     = OUT_BELOW_WAKE_I;
	assign pins[`SY_A92]      = OUT_ABOVE_92_I;
	assign pins[`SY_B90]      = OUT_BELOW_90_I;
	assign pins[`SY_QTR]      = OUT_BELOW_QUARTER_I;

	assign f       = st_ff.filt;
	assign swing   = (st_ff.pwr == PWR_RAMP) || (st_ff.pwr == PWR_RUN);
	assign stop    = !st_ff.en || f[`SY_UVLO];
	assign go      = st_ff.en && !f[`SY_UVLO] && !f[`SY_HOT];
	assign cfg_rst = f[`SY_UVLO] || !f[`SY_IOV];

	always_comb begin
		nxt_st = st_ff;
		hic = 1'b0;
		// comparator synchronisers
		nxt_st.sync1 = pins;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		nxt_st.filt  = settle(st_ff.sync2, st_ff.sync3, st_ff.filt);

		// configuration; the reset source wins over a same-cycle write
		if (cfg_rst) begin
			nxt_st.sw_on     = 1'b0;
			nxt_st.ctl_and   = 1'b0;
			nxt_st.ramp_fast = 1'b0;
			nxt_st.vout      = VOUT_DEFAULT;
			nxt_st.peak      = `PEAK_RST;
		end else if (WE_I) begin
			case (ADDR_I)
				`ADDR_CTRL: begin
					nxt_st.sw_on     = WDATA_I[`CTRL_SW_ON];
					nxt_st.ctl_and   = WDATA_I[`CTRL_AND];
					nxt_st.ramp_fast = WDATA_I[`CTRL_FAST];
				end
				`ADDR_VOUT: begin
					// codes past 7.5V saturate
					nxt_st.vout = (WDATA_I[6:0] > `VOUT_MAX) ?
						`VOUT_MAX : WDATA_I[6:0];
				end
				`ADDR_PEAK: begin
					if (!f[`SY_STRAP]) begin
						nxt_st.peak = WDATA_I[1:0];
					end
				end
				default: begin
				end
			endcase
		end

		nxt_st.rdata = 8'h00;
		if (RE_I) begin
			case (ADDR_I)
				`ADDR_CTRL: nxt_st.rdata = {5'h00, st_ff.ramp_fast,
					st_ff.ctl_and, st_ff.sw_on};
				`ADDR_VOUT: nxt_st.rdata = {1'b0, st_ff.vout};
				`ADDR_PEAK: nxt_st.rdata = {5'h00, f[`SY_STRAP],
					st_ff.peak};
				`ADDR_STAT: nxt_st.rdata = {st_ff.bias_out, st_ff.ramp,
					st_ff.pwr == PWR_RETRY, st_ff.pg, st_ff.stby,
					st_ff.en, st_ff.b_on, st_ff.a_on};
				default: nxt_st.rdata = 8'h00;
			endcase
		end

		nxt_st.en = st_ff.ctl_and ? (f[`SY_EN] & st_ff.sw_on) :
			(f[`SY_EN] | st_ff.sw_on);

		// 1MHz switching clock
		nxt_st.tick_cnt = (st_ff.tick_cnt == 8'(`SW_PERIOD_CYC - 1)) ?
			8'h00 : st_ff.tick_cnt + 8'h01;
		nxt_st.tick = (st_ff.tick_cnt == 8'h00);

		// switch sequencer; dropping out of swing opens both at once
		if (!swing) begin
			nxt_st.phase = PH_IDLE;
			nxt_st.dead  = 4'h0;
		end else begin
			case (st_ff.phase)
				PH_IDLE: begin
					if (st_ff.tick) begin
						nxt_st.phase = PH_DEAD_H;
						nxt_st.dead  = 4'(`DEAD_CYC - 1);
					end
				end
				PH_DEAD_H: begin
					if (st_ff.dead == 4'h0) begin
						nxt_st.phase = PH_HIGH;
					end else begin
						nxt_st.dead = st_ff.dead - 4'h1;
					end
				end
				PH_HIGH: begin
					if (f[`SY_TRIP] || f[`SY_LIM]) begin
						nxt_st.phase = PH_DEAD_L;
						nxt_st.dead  = 4'(`DEAD_CYC - 1);
						if (f[`SY_LIM] && f[`SY_QTR]) begin
							nxt_st.peak_limit_strap_cnt = st_ff.peak_limit_strap_cnt + 4'h1;
							hic = (st_ff.peak_limit_strap_cnt ==
								`HICCUP_LIM - 4'h1);
						end else begin
							nxt_st.peak_limit_strap_cnt = 4'h0;
						end
					end
				end
				PH_DEAD_L: begin
					if (st_ff.dead == 4'h0) begin
						nxt_st.phase = PH_LOW;
					end else begin
						nxt_st.dead = st_ff.dead - 4'h1;
					end
				end
				PH_LOW: begin
					if (f[`SY_ZX]) begin
						nxt_st.phase = PH_IDLE;
					end else if (st_ff.tick) begin
						nxt_st.phase = PH_DEAD_H;
						nxt_st.dead  = 4'(`DEAD_CYC - 1);
					end
				end
				default: nxt_st.phase = PH_IDLE;
			endcase
		end

		// power state; every way into ramp reloads the soft-start timer
		case (st_ff.pwr)
			PWR_OFF: begin
				if (go) begin
					nxt_st.pwr = PWR_RAMP;
					nxt_st.tmr = st_ff.ramp_fast ? SS_FAST_CYC :
						SS_SLOW_CYC;
				end
			end
			PWR_RAMP, PWR_RUN: begin
				if (stop) begin
					nxt_st.pwr = PWR_OFF;
				end else if (f[`SY_HOT] || hic) begin
					nxt_st.pwr      = PWR_RETRY;
					nxt_st.tmr      = RETRY_CYC;
					nxt_st.peak_limit_strap_cnt = 4'h0;
				end else if (st_ff.pwr == PWR_RAMP) begin
					if (st_ff.tmr == 22'h0) begin
						nxt_st.pwr = PWR_RUN;
					end else begin
						nxt_st.tmr = dec22(st_ff.tmr);
					end
				end else if (st_ff.phase == PH_IDLE &&
					f[`SY_INREG] && f[`SY_LIGHT]) begin
					nxt_st.pwr = PWR_STBY;
				end
			end
			PWR_STBY: begin
				if (stop) begin
					nxt_st.pwr = PWR_OFF;
				end else if (f[`SY_WAKE]) begin
					nxt_st.pwr = PWR_RUN;
				end
			end
			PWR_RETRY: begin
				if (stop) begin
					nxt_st.pwr = PWR_OFF;
				end else if (st_ff.tmr == 22'h0 && !f[`SY_HOT]) begin
					nxt_st.pwr = PWR_RAMP;
					nxt_st.tmr = st_ff.ramp_fast ? SS_FAST_CYC :
						SS_SLOW_CYC;
				end else begin
					nxt_st.tmr = dec22(st_ff.tmr);
				end
			end
			default: nxt_st.pwr = PWR_OFF;
		endcase

		// supply mux; a gap cycle breaks one channel before the other
		if (!st_ff.en) begin
			nxt_st.mux = MUX_OFF;
		end else begin
			case (st_ff.mux)
				MUX_OFF: nxt_st.mux = f[`SY_A_HIGHER] ?
					MUX_A : MUX_B;
				MUX_A: begin
					if (f[`SY_B_OVER_A]) begin
						nxt_st.mux = MUX_GAP_B;
					end
				end
				MUX_B: begin
					if (f[`SY_A_OVER_B]) begin
						nxt_st.mux = MUX_GAP_A;
					end
				end
				MUX_GAP_A: nxt_st.mux = MUX_A;
				MUX_GAP_B: nxt_st.mux = MUX_B;
				default:   nxt_st.mux = MUX_OFF;
			endcase
		end

		// output good hysteresis; falling threshold has priority
		if (f[`SY_B90]) begin
			nxt_st.pg = 1'b0;
		end else if (f[`SY_A92]) begin
			nxt_st.pg = 1'b1;
		end

		nxt_st.a_on = (nxt_st.mux == MUX_A);
		nxt_st.b_on = (nxt_st.mux == MUX_B);
		nxt_st.hs   = (nxt_st.phase == PH_HIGH);
		nxt_st.ls   = (nxt_st.phase == PH_LOW);
		nxt_st.hiz  = (nxt_st.pwr != PWR_RAMP) &&
			(nxt_st.pwr != PWR_RUN);
		nxt_st.stby = (nxt_st.pwr == PWR_STBY);
		nxt_st.ramp = (nxt_st.pwr == PWR_RAMP);
		// bias follows the output only once it regulates
		nxt_st.bias_out = INTERNAL_FB && f[`SY_INREG] &&
			(st_ff.vout >= `VOUT_BIAS_LO) &&
			(st_ff.vout <= `VOUT_BIAS_HI) &&
			(st_ff.pwr == PWR_RUN || st_ff.pwr == PWR_STBY);
		nxt_st.bias_on = (f[`SY_EN] || f[`SY_IOV]) &&
			!nxt_st.bias_out;
		nxt_st.pg_oe    = !nxt_st.pg;
		nxt_st.peak_eff = f[`SY_STRAP] ? `PEAK_FIXED :
			st_ff.peak;
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_ff         <= '0;
			st_ff.vout    <= VOUT_DEFAULT;
			st_ff.hiz     <= 1'b1;
			st_ff.pg_oe   <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign RDATA_O               = st_ff.rdata;
	assign SUPPLY_A_ON_O         = st_ff.a_on;
	assign SUPPLY_B_ON_O         = st_ff.b_on;
	assign HIGH_SIDE_SWITCH_O    = st_ff.hs;
	assign LOW_SIDE_SWITCH_O     = st_ff.ls;
	assign SWITCH_NODE_HIZ_O     = st_ff.hiz;
	assign STANDBY_O             = st_ff.stby;
	assign RAMP_ACTIVE_O         = st_ff.ramp;
	assign PEAK_LIMIT_O          = st_ff.peak_eff;
	assign VOUT_CODE_O           = st_ff.vout;
	assign BIAS_REG_ON_O         = st_ff.bias_on;
	assign BIAS_TO_OUT_O         = st_ff.bias_out;
	// open drain: only ever pulls low
	assign OUTPUT_GOOD_FLAG_O    = 1'b0;
	assign OUTPUT_GOOD_FLAG_OE_O = st_ff.pg_oe;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	localparam int ON_DLY = `DEAD_CYC + 1;

	AST_MUX_EXCL: assert property (
		!(SUPPLY_A_ON_O && SUPPLY_B_ON_O))
		else $error("both supply channels on");
	AST_MUX_DIS: assert property (
		!st_ff.en |=> !SUPPLY_A_ON_O && !SUPPLY_B_ON_O)
		else $error("channel on while disabled");
	AST_XOVER: assert property (
		$rose(SUPPLY_B_ON_O) && $past(SUPPLY_A_ON_O, 2)
		|-> $past(st_ff.filt[`SY_B_OVER_A], 2))
		else $error("switchover without hysteresis margin");
	AST_ON_START: assert property (
		$rose(HIGH_SIDE_SWITCH_O) |-> $past(st_ff.tick, ON_DLY))
		else $error("on-time not started by clock pulse");
	AST_ON_END: assert property (
		$fell(HIGH_SIDE_SWITCH_O) |-> $past(f[`SY_TRIP] ||
		f[`SY_LIM] || !swing))
		else $error("on-time ended without comparator");
	AST_DEAD: assert property (
		$fell(HIGH_SIDE_SWITCH_O) || $fell(LOW_SIDE_SWITCH_O)
		|-> (!HIGH_SIDE_SWITCH_O && !LOW_SIDE_SWITCH_O) [*2])
		else $error("dead time too short");
	AST_ZX: assert property (
		LOW_SIDE_SWITCH_O && st_ff.filt[`SY_ZX] |=> !LOW_SIDE_SWITCH_O)
		else $error("low side stayed on after zero cross");
	AST_WAKE: assert property (
		STANDBY_O && st_ff.filt[`SY_WAKE] |=> !STANDBY_O)
		else $error("standby did not wake");
	AST_EN: assert property (
		st_ff.en == $past(st_ff.ctl_and ? (f[`SY_EN] & st_ff.sw_on) :
		(f[`SY_EN] | st_ff.sw_on)))
		else $error("enable combine wrong");
	AST_PG_LOW: assert property (
		st_ff.filt[`SY_B90] |=> OUTPUT_GOOD_FLAG_OE_O)
		else $error("output good not pulled low");
	AST_PG_HI: assert property (
		st_ff.filt[`SY_A92] && !st_ff.filt[`SY_B90]
		|=> !OUTPUT_GOOD_FLAG_OE_O)
		else $error("output good not released");
	AST_PEAK: assert property (
		st_ff.filt[`SY_STRAP] |=> PEAK_LIMIT_O == `PEAK_FIXED)
		else $error("strap high but limit not fixed");

	COV_XOVER: cover property (
		$rose(SUPPLY_B_ON_O) && $past(SUPPLY_A_ON_O, 2));
	COV_STBY: cover property ($rose(STANDBY_O));
	COV_RETRY: cover property (st_ff.pwr == PWR_RETRY);
	COV_DCM: cover property (
		LOW_SIDE_SWITCH_O && st_ff.filt[`SY_ZX]);
endmodule

// >>> bench/power_stage_model.sv
`timescale 1ns/1ns
// behavioural switches and inductor: current rises while the high side
// conducts and decays to zero after it stops, sooner while the low side conducts
module power_stage_model #(
	parameter int ON_CYC  = 5,
	parameter int OFF_CYC = 7
) (
	// clock
	input  wire logic clk_i,
	// switch drives
	input  wire logic high_i,
	input  wire logic low_i,
	// comparator outputs
	output logic      trip_o,
	output logic      zero_cross_o
);
	int on_cnt;
	int off_cnt;

	always_ff @(posedge clk_i) begin
		on_cnt  <= high_i ? on_cnt + 1 : 0;
		// current decays faster while the low side conducts than in dead time
		off_cnt <= high_i ? 0 : (low_i ? off_cnt + 2 : off_cnt + 1);
	end
	// trip stays up until the high side is dropped, like a real comparator
	assign trip_o       = high_i && (on_cnt >= ON_CYC);
	assign zero_cross_o = !high_i && (off_cnt >= OFF_CYC);
endmodule

// >>> bench/buck_mux_control_logic_test.sv
`timescale 1ns/1ns
`include "buck_params.svh"
module buck_mux_control_logic_test;
	import buck_pkg::*;
	localparam int SS_SLOW = 40;
	localparam int SS_FAST = 20;
	logic       clk;
	logic       nrst;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       we;
	logic       re;
	logic [7:0] rdata;
	logic       en_pin, iface_ok, uvlo, hot, strap;
	logic       a_higher, a_over_b, b_over_a, trip, cur_lim, zx;
	logic       in_reg, light, wake, above92, below90, quarter;
	logic       a_on, b_on, hs, ls, hiz, stby, ramp;
	logic [1:0] peak;
	logic [6:0] vout;
	logic       bias_on, bias_out, pg, pg_oe;
	logic [7:0] d;
	int         n;
	int         per;
	int         cyc;
	int         error_cnt;
	int         tests_run;

	buck_mux_control_logic #(
		.SS_SLOW_CYC (22'(SS_SLOW)),
		.SS_FAST_CYC (22'(SS_FAST)),
		.RETRY_CYC   (22'h3c)
	) buck_mux_control_logic_i (
		.CLK_I (clk), .NRST_I (nrst),
		.ADDR_I (addr), .WDATA_I (wdata), .WE_I (we), .RE_I (re),
		.RDATA_O (rdata),
		.EN_PIN_I (en_pin), .IFACE_SUPPLY_VALID_I (iface_ok),
		.SUP_UVLO_I (uvlo), .OVERTEMP_I (hot),
		.PEAK_LIMIT_STRAP_I (strap),
		.SUPPLY_A_HIGHER_I (a_higher), .SUPPLY_A_OVER_B_I (a_over_b),
		.SUPPLY_B_OVER_A_I (b_over_a),
		.PWM_TRIP_I (trip), .CUR_LIMIT_I (cur_lim), .ZERO_CROSS_I (zx),
		.OUT_IN_REG_I (in_reg), .LIGHT_LOAD_I (light),
		.OUT_BELOW_WAKE_I (wake), .OUT_ABOVE_92_I (above92),
		.OUT_BELOW_90_I (below90), .OUT_BELOW_QUARTER_I (quarter),
		.SUPPLY_A_ON_O (a_on), .SUPPLY_B_ON_O (b_on),
		.HIGH_SIDE_SWITCH_O (hs), .LOW_SIDE_SWITCH_O (ls),
		.SWITCH_NODE_HIZ_O (hiz), .STANDBY_O (stby),
		.RAMP_ACTIVE_O (ramp), .PEAK_LIMIT_O (peak), .VOUT_CODE_O (vout),
		.BIAS_REG_ON_O (bias_on), .BIAS_TO_OUT_O (bias_out),
		.OUTPUT_GOOD_FLAG_O (pg), .OUTPUT_GOOD_FLAG_OE_O (pg_oe)
	);

	power_stage_model power_stage_model_i (
		.clk_i (clk), .high_i (hs), .low_i (ls),
		.trip_o (trip), .zero_cross_o (zx)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		we    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		we    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		re   <= 1'b1;
		addr <= a;
		@(posedge clk);
		re   <= 1'b0;
		#1;
		v = rdata;
	endtask

	// bounded wait for one output to reach a level, cycles counted in k
	task automatic wait_pin(input int sel, input logic lvl, output int k);
		logic s;
		k = 0;
		s = (sel == 0) ? hs : (sel == 1) ? ls : (sel == 2) ? ramp : stby;
		while (s !== lvl && k < 400) begin
			@(posedge clk);
			#1;
			k++;
			s = (sel == 0) ? hs : (sel == 1) ? ls : (sel == 2) ? ramp : stby;
		end
		if (k >= 400) begin
			error_cnt++;
			$display("[FAIL] t=%0t wait sel=%h", $time, sel[7:0]);
		end
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	initial begin
		{addr, wdata, we, re} = '0;
		{en_pin, uvlo, hot, strap, cur_lim, quarter} = '0;
		{a_higher, a_over_b, b_over_a} = '0;
		{in_reg, light, wake, above92, below90} = '0;
		iface_ok = 1'b1;
		nrst = 1'b0;
		cyc = 0;
		error_cnt = 0;
		tests_run = 0;
		idle(4);
		nrst = 1'b1;
		idle(6);
		chk({6'h0, a_on, b_on}, 8'h00);
		chk({7'h0, pg_oe}, 8'h01);
		chk({7'h0, bias_on}, 8'h01);
		rd(`ADDR_CTRL, d);
		chk(d, 8'h00);
		rd(`ADDR_PEAK, d);
		chk(d, 8'h00);
		chk({1'b0, vout}, {1'b0, `VOUT_RST});
		// enable combining, all eight combinations
		a_higher <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr(`ADDR_CTRL, {6'h0, i[2], i[0]});
			@(posedge clk);
			en_pin <= i[1];
			idle(8);
			rd(`ADDR_STAT, d);
			chk({7'h0, d[2]}, {7'h0, i[2] ? i[1] & i[0] : i[1] | i[0]});
		end
		chk({7'h0, ramp}, 8'h01);
		chk({6'h0, a_on, b_on}, 8'h02);
		// a lead without hysteresis margin must not move the switch
		@(posedge clk);
		a_higher <= 1'b0;
		idle(8);
		chk({6'h0, a_on, b_on}, 8'h02);
		@(posedge clk);
		b_over_a <= 1'b1;
		idle(8);
		chk({6'h0, a_on, b_on}, 8'h01);
		// one full switching period, measured from a clean rising edge
		wait_pin(0, 1'b0, n);
		wait_pin(0, 1'b1, n);
		wait_pin(0, 1'b0, per);
		wait_pin(1, 1'b1, n);
		chk({7'h0, n >= 2}, 8'h01);
		per += n;
		wait_pin(1, 1'b0, n);
		per += n;
		chk({7'h0, hs}, 8'h00);
		wait_pin(0, 1'b1, n);
		chk(8'(per + n), 8'(`SW_PERIOD_CYC));
		chk({7'h0, per > 0}, 8'h01);
		// standby on light load, wake on droop
		@(posedge clk);
		in_reg <= 1'b1;
		light  <= 1'b1;
		wait_pin(3, 1'b1, n);
		chk({7'h0, hiz}, 8'h01);
		@(posedge clk);
		{in_reg, light, wake} <= 3'b001;
		wait_pin(3, 1'b0, n);
		chk({7'h0, n <= 6}, 8'h01);
		// soft-start length for both settings
		for (int f = 1; f >= 0; f--) begin
			@(posedge clk);
			en_pin <= 1'b0;
			wr(`ADDR_CTRL, {5'h0, f[0], 2'h0});
			idle(8);
			chk({5'h0, a_on, b_on, hiz}, 8'h01);
			@(posedge clk);
			en_pin <= 1'b1;
			wait_pin(2, 1'b1, n);
			wait_pin(2, 1'b0, n);
			per = f ? SS_FAST : SS_SLOW;
			chk({7'h0, n >= per - 2 && n <= per + 2}, 8'h01);
		end
		// bias onto output once regulating inside the 3.3V to 5.0V codes
		@(posedge clk);
		in_reg <= 1'b1;
		idle(6);
		chk({6'h0, bias_out, bias_on}, 8'h02);
		// limited on-times below a quarter of target start a hiccup
		@(posedge clk);
		{in_reg, cur_lim, quarter} <= 3'b011;
		per = 0;
		d = 8'h00;
		while (!d[5] && per < 2500) begin
			rd(`ADDR_STAT, d);
			per++;
		end
		chk({7'h0, d[5]}, 8'h01);
		chk({7'h0, per > 1700}, 8'h01);
		chk({6'h0, hs, hiz}, 8'h01);
		@(posedge clk);
		{cur_lim, quarter} <= 2'b00;
		wait_pin(2, 1'b1, n);
		chk({7'h0, ramp}, 8'h01);
		// peak limit field and strap
		for (int i = 0; i < 4; i++) begin
			wr(`ADDR_PEAK, 8'(i));
			idle(1);
			chk({6'h0, peak}, 8'(i));
		end
		@(posedge clk);
		strap <= 1'b1;
		idle(8);
		wr(`ADDR_PEAK, 8'h00);
		rd(`ADDR_PEAK, d);
		chk(d, 8'h07);
		chk({6'h0, peak}, 8'h03);
		@(posedge clk);
		strap <= 1'b0;
		// target code range and an unmapped address
		wr(`ADDR_VOUT, 8'h7f);
		rd(`ADDR_VOUT, d);
		chk(d, {1'b0, `VOUT_MAX});
		wr(`ADDR_VOUT, 8'h00);
		idle(1);
		chk({1'b0, vout}, 8'h00);
		wr(8'h10, 8'hff);
		rd(8'h10, d);
		chk(d, 8'h00);
		// output good hysteresis
		@(posedge clk);
		above92 <= 1'b1;
		idle(6);
		chk({7'h0, pg_oe}, 8'h00);
		chk({7'h0, pg}, 8'h00);
		@(posedge clk);
		{above92, below90} <= 2'b01;
		idle(6);
		chk({7'h0, pg_oe}, 8'h01);
		// undervoltage or an invalid interface supply wipes configuration
		wr(`ADDR_PEAK, 8'h02);
		@(posedge clk);
		uvlo <= 1'b1;
		idle(8);
		rd(`ADDR_PEAK, d);
		chk(d, 8'h00);
		chk({1'b0, vout}, {1'b0, `VOUT_RST});
		@(posedge clk);
		{uvlo, iface_ok} <= 2'b00;
		idle(8);
		wr(`ADDR_CTRL, 8'h01);
		rd(`ADDR_CTRL, d);
		chk(d, 8'h00);
		complete_run();
	end
endmodule
